// ### src/status_event_summary_params.svh
`ifndef STATUS_EVENT_SUMMARY_PARAMS_SVH
`define STATUS_EVENT_SUMMARY_PARAMS_SVH

// Width of each status register set.
`define REG_W 16
// Depth of each queue and width of its entries.
`define QUEUE_DEPTH 8
`define QUEUE_PTR_W 3
`define QUEUE_CNT_W 4
`define QUEUE_DATA_W 8
// Reset value of every status register.
`define REG_RESET 16'h0000
// Status byte bit positions.
`define SB_MEAS_BIT 0
`define SB_ERRQ_BIT 2
`define SB_QUES_BIT 3
`define SB_MSGQ_BIT 4
`define SB_STD_BIT 5
`define SB_MSS_BIT 6
`define SB_OPER_BIT 7
// Register set indices.
`define SET_STD 0
`define SET_OPER 1
`define SET_MEAS 2
`define SET_QUES 3
`define NUM_SETS 4

`endif

// ### src/status_event_summary_pkg.sv
`include "status_event_summary_params.svh"

package status_event_summary_pkg;

    // One register word of a status set.
    typedef logic [`REG_W-1:0] status_word_t;

    // Per-set host commands: enable write and event read strobes.
    typedef struct packed {
        logic         enable_write;
        status_word_t enable_data;
        logic         event_read;
    } set_cmd_s;

    // Per-set readback: condition, event and enable words.
    typedef struct packed {
        status_word_t condition;
        status_word_t event_bits;
        status_word_t enable;
    } set_view_s;

    // Queue push and pop request group.
    typedef struct packed {
        logic                     push;
        logic [`QUEUE_DATA_W-1:0] push_data;
        logic                     pop;
    } queue_cmd_s;

    // Global commands from the command decoder.
    typedef struct packed {
        logic clear_status;
        logic status_preset;
        logic status_queue_clear;
        logic system_error_clear;
        logic system_preset;
        logic instrument_reset;
    } global_cmd_s;

endpackage

// ### src/status_event_summary.sv
// Notes on behaviour
// - Event bits latch until register is reset.
// - Set summary is OR of event AND enable.
// - Condition registers read-only, mirror live state.
// - Status byte takes four sets, two queues.
// - Master summary when enabled status bit set.
// - Queue summary set when queue non-empty.
// - Responses to output queue, errors to error.
// - Power-up clears registers, empties both queues.
// - Writing zero clears an enable register.
// - System preset and reset change nothing here.
// - Clear-status clears events and error queue.
// - Status preset clears three enable registers.
// - Status preset leaves error queue intact.
// - Standard enable cleared only by own write.
// - Either queue-clear command empties error queue.
// - Status byte bits follow summaries, no latch.
// - Reading an event register clears it.
// - Only enable registers are host-writable.
`timescale 1ns/1ps
`include "status_event_summary_params.svh"
`default_nettype none

module status_event_summary
    import status_event_summary_pkg::*;
(
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire status_word_t             condition_in [`NUM_SETS],
    input  wire set_cmd_s                 set_cmd      [`NUM_SETS],
    input  wire global_cmd_s              global_cmd,
    input  wire logic [7:0]               service_enable_data,
    input  wire logic                     service_enable_write,
    input  wire queue_cmd_s               output_queue_cmd,
    input  wire queue_cmd_s               error_queue_cmd,
    output logic                          output_queue_ready,
    output logic                          error_queue_ready,
    output logic [`QUEUE_DATA_W-1:0]      output_queue_head,
    output logic [`QUEUE_DATA_W-1:0]      error_queue_head,
    output set_view_s                     set_view     [`NUM_SETS],
    output logic [7:0]                    status_byte,
    output logic [7:0]                    service_enable,
    output logic                          service_request
);

    // Condition inputs pass two flip-flops; the second stage is the live mirror.
    status_word_t cond_meta [`NUM_SETS];    // First synchroniser stage.
    status_word_t cond_sync [`NUM_SETS];    // Second stage, the condition register.
    status_word_t cond_prev [`NUM_SETS];    // Previous sample for edge detection.
    status_word_t event_reg [`NUM_SETS];    // Latched event registers.
    status_word_t enable_reg [`NUM_SETS];   // Event enable registers.
    status_word_t next_event [`NUM_SETS];   // Next event values.
    status_word_t next_enable [`NUM_SETS];  // Next enable values.
    logic [`NUM_SETS-1:0] set_summary;      // Summary output of each set.

    // Error queue clears from any of the three clearing commands.
    wire error_queue_flush = global_cmd.clear_status
                           | global_cmd.status_queue_clear
                           | global_cmd.system_error_clear;

    // System preset and instrument reset are accepted and intentionally unused here.
    wire preset_ignored = global_cmd.system_preset | global_cmd.instrument_reset;

    // Summary of one set: any enabled latched event.
    function automatic logic set_sum(input status_word_t ev, input status_word_t en);
        set_sum = |(ev & en);
    endfunction

    // Next event word: new rising edges are set after any clear, so they win.
    function automatic status_word_t event_update(
        input status_word_t ev,
        input status_word_t now_c,
        input status_word_t old_c,
        input logic         clr
    );
        status_word_t rise;
        rise = now_c & ~old_c;
        event_update = (clr ? `REG_RESET : ev) | rise;
    endfunction

    // Per-set combinational next-state and summary logic.
    genvar s;
    generate
        for (s = 0; s < `NUM_SETS; s++)
        begin : g_set
            // Event reads and clear-status reset the event register.
            wire clr_ev = set_cmd[s].event_read | global_cmd.clear_status;
            // Status preset clears all enables but the standard set's.
            wire preset_hit = global_cmd.status_preset && (s != `SET_STD);

            assign next_event[s] = event_update(event_reg[s], cond_sync[s], cond_prev[s],
                                                clr_ev);
            // A written value, zero included, replaces the whole enable word.
            assign next_enable[s] = set_cmd[s].enable_write ? set_cmd[s].enable_data
                                  : (preset_hit ? `REG_RESET : enable_reg[s]);
            assign set_summary[s] = set_sum(event_reg[s], enable_reg[s]);

            // Readback view; condition is the live mirror.
            assign set_view[s].condition  = cond_sync[s];
            assign set_view[s].event_bits = event_reg[s];
            assign set_view[s].enable     = enable_reg[s];
        end
    endgenerate

    // Register-set state, cleared at power-up.
    always_ff @(posedge core_clk)
    begin
        for (int i = 0; i < `NUM_SETS; i++)
        begin
            if (!rst_n)
            begin
                cond_meta[i]  <= `REG_RESET;
                cond_sync[i]  <= `REG_RESET;
                cond_prev[i]  <= `REG_RESET;
                event_reg[i]  <= `REG_RESET;
                enable_reg[i] <= `REG_RESET;
            end
            else
            begin
                cond_meta[i]  <= condition_in[i];
                cond_sync[i]  <= cond_meta[i];
                cond_prev[i]  <= cond_sync[i];
                event_reg[i]  <= next_event[i];
                enable_reg[i] <= next_enable[i];
            end
        end
    end

    // Output queue storage and pointers.
    logic [`QUEUE_DATA_W-1:0] oq_mem [`QUEUE_DEPTH];  // Query responses.
    logic [`QUEUE_PTR_W-1:0]  oq_wr;                  // Write pointer.
    logic [`QUEUE_PTR_W-1:0]  oq_rd;                  // Read pointer.
    logic [`QUEUE_CNT_W-1:0]  oq_cnt;                 // Entry count.
    // Error queue storage and pointers.
    logic [`QUEUE_DATA_W-1:0] eq_mem [`QUEUE_DEPTH];  // Error and status messages.
    logic [`QUEUE_PTR_W-1:0]  eq_wr;                  // Write pointer.
    logic [`QUEUE_PTR_W-1:0]  eq_rd;                  // Read pointer.
    logic [`QUEUE_CNT_W-1:0]  eq_cnt;                 // Entry count.

    // Queue handshake decoding.
    wire oq_empty = (oq_cnt == '0);
    wire eq_empty = (eq_cnt == '0);
    wire oq_full  = (oq_cnt == `QUEUE_CNT_W'(`QUEUE_DEPTH));
    wire eq_full  = (eq_cnt == `QUEUE_CNT_W'(`QUEUE_DEPTH));
    wire oq_push  = output_queue_cmd.push & ~oq_full;
    wire oq_pop   = output_queue_cmd.pop & ~oq_empty;
    wire eq_push  = error_queue_cmd.push & ~eq_full & ~error_queue_flush;
    wire eq_pop   = error_queue_cmd.pop & ~eq_empty;

    assign output_queue_ready = ~oq_full;
    assign error_queue_ready  = ~eq_full;
    assign output_queue_head  = oq_mem[oq_rd];
    assign error_queue_head   = eq_mem[eq_rd];

    // Output queue: status preset and the clear commands do not touch it.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            oq_wr  <= '0;
            oq_rd  <= '0;
            oq_cnt <= '0;
        end
        else
        begin
            if (oq_push)
            begin
                oq_mem[oq_wr] <= output_queue_cmd.push_data;
                oq_wr         <= oq_wr + 1'b1;
            end
            if (oq_pop)
            begin
                oq_rd <= oq_rd + 1'b1;
            end
            oq_cnt <= oq_cnt + `QUEUE_CNT_W'(oq_push) - `QUEUE_CNT_W'(oq_pop);
        end
    end

    // Error queue: a flush empties it; status preset alone leaves it.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || error_queue_flush)
        begin
            eq_wr  <= '0;
            eq_rd  <= '0;
            eq_cnt <= '0;
        end
        else
        begin
            if (eq_push)
            begin
                eq_mem[eq_wr] <= error_queue_cmd.push_data;
                eq_wr         <= eq_wr + 1'b1;
            end
            if (eq_pop)
            begin
                eq_rd <= eq_rd + 1'b1;
            end
            eq_cnt <= eq_cnt + `QUEUE_CNT_W'(eq_push) - `QUEUE_CNT_W'(eq_pop);
        end
    end

    // Service request enable register; bit 6 is never enabled.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            service_enable <= 8'h00;
        end
        else if (service_enable_write)
        begin
            service_enable <= service_enable_data & ~(8'h01 << `SB_MSS_BIT);
        end
    end

    // Status byte summaries without the master bit; they follow sources directly.
    logic [7:0] summary_bits;
    always_comb
    begin
        summary_bits               = 8'h00;
        summary_bits[`SB_MEAS_BIT] = set_summary[`SET_MEAS];
        summary_bits[`SB_ERRQ_BIT] = ~eq_empty;
        summary_bits[`SB_QUES_BIT] = set_summary[`SET_QUES];
        summary_bits[`SB_MSGQ_BIT] = ~oq_empty;
        summary_bits[`SB_STD_BIT]  = set_summary[`SET_STD];
        summary_bits[`SB_OPER_BIT] = set_summary[`SET_OPER];
    end

    // Master summary from any enabled summary bit.
    wire master_summary = |(summary_bits & service_enable);

    // Status byte register output, refreshed every cycle.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            status_byte     <= 8'h00;
            service_request <= 1'b0;
        end
        else
        begin
            status_byte     <= summary_bits | ({7'h00, master_summary} << `SB_MSS_BIT);
            service_request <= master_summary;
        end
    end

endmodule
`default_nettype wire

// ### verification/status_host_model.sv
`timescale 1ns/1ps
`include "status_event_summary_params.svh"
`default_nettype none
// Host program model: sends one-cycle command strobes to the status block.
module status_host_model
    import status_event_summary_pkg::*;
(
    input  wire logic       core_clk,
    output var set_cmd_s    set_cmd [`NUM_SETS],
    output var global_cmd_s global_cmd,
    output logic [7:0]      service_enable_data,
    output logic            service_enable_write,
    output var queue_cmd_s  output_queue_cmd,
    output var queue_cmd_s  error_queue_cmd
);
    // All strobes start idle.
    initial
    begin
        foreach (set_cmd[k])
            set_cmd[k] = '0;
        global_cmd = '0;
        service_enable_data = 8'h00;
        service_enable_write = 1'b0;
        output_queue_cmd = '0;
        error_queue_cmd = '0;
    end
    // Global command strobe held for one cycle.
    task automatic gpulse(input global_cmd_s g);
        @(posedge core_clk);
        global_cmd <= g;
        @(posedge core_clk);
        global_cmd <= '0;
    endtask
    // Enable write or event read of one set; a zero word clears the enable.
    task automatic setop(input int k, input logic wr, input status_word_t d);
        @(posedge core_clk);
        set_cmd[k] <= '{wr, d, !wr};
        @(posedge core_clk);
        set_cmd[k] <= '0;
    endtask
    // Service request enable write.
    task automatic swrite(input logic [7:0] d);
        @(posedge core_clk);
        service_enable_data <= d;
        service_enable_write <= 1'b1;
        @(posedge core_clk);
        service_enable_write <= 1'b0;
    endtask
    // Push or pop on either queue.
    task automatic qcmd(input logic err, input logic push, input logic [7:0] d);
        @(posedge core_clk);
        if (err)
            error_queue_cmd <= '{push, d, !push};
        else
            output_queue_cmd <= '{push, d, !push};
        @(posedge core_clk);
        error_queue_cmd <= '0;
        output_queue_cmd <= '0;
    endtask
endmodule
`default_nettype wire

// ### verification/status_event_summary_assertions.sv
`timescale 1ns/1ps
`include "status_event_summary_params.svh"
`default_nettype none
// Watches summaries, clears and enable writes at the block's ports.
module status_event_summary_assertions
    import status_event_summary_pkg::*;
(
    input wire logic         core_clk,
    input wire logic         rst_n,
    input wire status_word_t condition_in [`NUM_SETS],
    input wire set_cmd_s     set_cmd [`NUM_SETS],
    input wire global_cmd_s  global_cmd,
    input wire set_view_s    set_view [`NUM_SETS],
    input wire logic [7:0]   status_byte,
    input wire logic         service_request
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_req_mss: assert property (service_request == status_byte[`SB_MSS_BIT])
        else $error("service request differs from master bit");
    a_std_summary: assert property (
        status_byte[`SB_STD_BIT] == $past(|(set_view[0].event_bits & set_view[0].enable)))
        else $error("standard summary bit wrong");
    a_oper_summary: assert property (
        status_byte[`SB_OPER_BIT] == $past(|(set_view[1].event_bits & set_view[1].enable)))
        else $error("operation summary bit wrong");
    a_event_latch: assert property (
        !set_cmd[0].event_read && !global_cmd.clear_status |=>
        (set_view[0].event_bits & $past(set_view[0].event_bits)) == $past(set_view[0].event_bits))
        else $error("event bit dropped without clear");
    a_read_clears: assert property (
        set_cmd[0].event_read && $stable(set_view[0].condition) |=>
        set_view[0].event_bits == '0)
        else $error("event read did not clear");
    a_cls_clears: assert property (
        global_cmd.clear_status && $stable(set_view[2].condition) |=>
        set_view[2].event_bits == '0)
        else $error("clear status left event bits");
    a_preset_enables: assert property (
        global_cmd.status_preset && !set_cmd[3].enable_write |=> set_view[3].enable == '0)
        else $error("status preset left enable bits");
    a_std_enable_kept: assert property (
        (global_cmd.status_preset || global_cmd.clear_status) && !set_cmd[0].enable_write
        |=> $stable(set_view[0].enable))
        else $error("standard enable changed by global command");
    a_cond_mirror: assert property (set_view[0].condition == $past(condition_in[0], 2))
        else $error("condition view does not follow input");
    a_enable_write: assert property (
        set_cmd[2].enable_write && !global_cmd.status_preset |=>
        set_view[2].enable == $past(set_cmd[2].enable_data))
        else $error("enable write not taken");
    a_rise_wins: assert property (
        set_cmd[1].event_read |=> set_view[1].event_bits
            == ($past(set_view[1].condition) & ~$past(set_view[1].condition, 2)))
        else $error("event lost to a simultaneous read");
    c_read: cover property (set_cmd[0].event_read);
    c_clear: cover property (global_cmd.clear_status);
    c_request: cover property ($rose(service_request));
endmodule
bind status_event_summary status_event_summary_assertions i_checker (.core_clk, .rst_n,
    .condition_in, .set_cmd, .global_cmd, .set_view, .status_byte, .service_request);
`default_nettype wire

// ### verification/tb_status_event_summary.sv
`timescale 1ns/1ps
`include "status_event_summary_params.svh"
`default_nettype none
module tb_status_event_summary
    import status_event_summary_pkg::*;
;
    logic         core_clk = 1'b0;
    logic         rst_n = 1'b0;
    status_word_t condition_in [`NUM_SETS];
    set_cmd_s     set_cmd [`NUM_SETS];
    global_cmd_s  global_cmd;
    logic [7:0]   service_enable_data, service_enable, status_byte;
    logic         service_enable_write, service_request;
    queue_cmd_s   output_queue_cmd, error_queue_cmd;
    logic         output_queue_ready, error_queue_ready;
    logic [7:0]   output_queue_head, error_queue_head;
    set_view_s    set_view [`NUM_SETS];
    int           err_count = 0;
    int           check_count = 0;
    // Reference model: events, enables, service enable and both queues.
    status_word_t ev [4];
    status_word_t en [4];
    logic [7:0]   sre = 8'h00;
    logic [7:0]   oq [$];
    logic [7:0]   eq [$];
    status_word_t r;
    always #2.5 core_clk = ~core_clk;
    status_host_model i_host (.core_clk, .set_cmd, .global_cmd, .service_enable_data,
        .service_enable_write, .output_queue_cmd, .error_queue_cmd);
    status_event_summary i_dut (.core_clk, .rst_n, .condition_in, .set_cmd, .global_cmd,
        .service_enable_data, .service_enable_write, .output_queue_cmd, .error_queue_cmd,
        .output_queue_ready, .error_queue_ready, .output_queue_head, .error_queue_head,
        .set_view, .status_byte, .service_enable, .service_request);
    // Expected status byte, built bit by bit from the model.
    function automatic logic [7:0] exp_sb();
        logic [7:0] b;
        b = {|(ev[1] & en[1]), 1'b0, |(ev[0] & en[0]), oq.size() > 0,
             |(ev[3] & en[3]), eq.size() > 0, 1'b0, |(ev[2] & en[2])};
        b[6] = |(b & sre);
        return b;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Lets every pipeline stage settle, then compares the view except the condition words.
    task automatic check_all(input string name);
        repeat (6) @(posedge core_clk);
        #1;
        for (int k = 0; k < 4; k++)
        begin
            chk(set_view[k].event_bits, ev[k]);
            chk(set_view[k].enable, en[k]);
        end
        chk(status_byte, exp_sb());
        chk(service_request, exp_sb() >> 6 & 1);
        chk(service_enable, sre);
        if (eq.size() > 0)
            chk(error_queue_head, eq[0]);
        if (oq.size() > 0)
            chk(output_queue_head, oq[0]);
        chk(output_queue_ready, oq.size() < 8);
        chk(error_queue_ready, eq.size() < 8);
        $display("test %s done", name);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        foreach (condition_in[k])
            condition_in[k] = '0;
        foreach (ev[k])
            ev[k] = '0;
        en = ev;
        void'($urandom(32'hd93e_593b));
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        check_all("reset");
        for (int k = 0; k < 4; k++)
        begin
            en[k] = status_word_t'($urandom | 1);
            i_host.setop(k, 1'b1, en[k]);
            r = status_word_t'($urandom | 1);
            @(posedge core_clk);
            condition_in[k] <= r;
            ev[k] |= r;
            check_all("rise");
            chk(set_view[k].condition, r);
            condition_in[k] <= '0;
            check_all("fall");
            chk(set_view[k].condition, 0);
        end
        sre = 8'hbf;
        i_host.swrite(8'hff);
        check_all("service");
        for (int i = 0; i < 5; i++)
        begin
            r = status_word_t'($urandom);
            i_host.qcmd(i < 3, 1'b1, r[7:0]);
            if (i < 3)
                eq.push_back(r[7:0]);
            else
                oq.push_back(r[7:0]);
        end
        i_host.gpulse(6'h03);
        check_all("no effect");
        i_host.gpulse(6'h10);
        en[1] = 0;
        en[2] = 0;
        en[3] = 0;
        check_all("preset");
        i_host.setop(0, 1'b0, 0);
        ev[0] = 0;
        check_all("read");
        i_host.setop(0, 1'b1, 0);
        en[0] = 0;
        i_host.gpulse(6'h20);
        ev = en;
        eq.delete();
        check_all("clear");
        // An event read lands in the very cycle in which a new rise is latched.
        r = status_word_t'($urandom | 1);
        @(posedge core_clk);
        condition_in[1] <= r;
        @(posedge core_clk);
        i_host.setop(1, 1'b0, 0);
        ev[1] = r;
        check_all("read and rise");
        for (int i = 0; i < 2; i++)
        begin
            i_host.qcmd(1'b1, 1'b1, 8'h5a);
            i_host.gpulse(i ? 6'h04 : 6'h08);
            check_all("queue clear");
        end
        for (int i = 0; i < 7; i++)
        begin
            r = status_word_t'($urandom);
            i_host.qcmd(1'b0, 1'b1, r[7:0]);
            if (oq.size() < 8)
                oq.push_back(r[7:0]);
        end
        check_all("full");
        while (oq.size() > 0)
        begin
            i_host.qcmd(1'b0, 1'b0, 8'h00);
            void'(oq.pop_front());
            check_all("pop");
        end
        complete_run();
    end
endmodule
`default_nettype wire
